//--- shared/link_act_pkg.sv
package link_act_pkg;
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned FRAME_TIME_US = 1500;
  localparam int unsigned FRAME_CYC     = CLK_HZ / 1_000_000 * FRAME_TIME_US;
  localparam int unsigned BD_W          = 18;

  // Wake tone lengths in frames
  localparam logic [2:0] NET_TONE_FRAMES  = 3'h6;
  localparam logic [2:0] LINE_TONE_FRAMES = 3'h2;
  localparam logic [2:0] TONE_LAST        = 3'h1;

  // Register indices, byte address is index times four
  localparam logic [3:0] R_ACT_STAT = 4'h0;
  localparam logic [3:0] R_ACT_CTRL = 4'h1;
  localparam logic [3:0] R_IRQ_EN   = 4'h2;
  localparam logic [3:0] R_IRQ_STAT = 4'h3;
  localparam logic [3:0] R_M4_RX    = 4'h4;
  localparam logic [3:0] R_M4_TX    = 4'h5;
  localparam logic [3:0] R_M56_RX   = 4'h6;
  localparam logic [3:0] R_M56_TX   = 4'h7;
  localparam logic [3:0] R_MNT_CTRL = 4'h8;
  localparam logic [3:0] R_MNT_MODE = 4'h9;
  localparam logic [3:0] R_EOC_RX   = 4'hA;
  localparam logic [3:0] R_EOC_TX   = 4'hB;
  localparam logic [3:0] R_LOOP     = 4'hC;
  localparam logic [3:0] R_ERR_CNT  = 4'hD;

  // Field positions
  localparam int ACT_REQ_BIT = 3;
  localparam int DEA_REQ_BIT = 2;
  localparam int ST_ERR_BIT  = 0;
  localparam int ST_SYNC_BIT = 1;
  localparam int ST_LVL_LSB  = 2;
  localparam int ST_WARM_BIT = 4;
  localparam int IRQ_EOC     = 2;
  localparam int IRQ_M4      = 1;
  localparam int IRQ_M56     = 0;
  localparam int M4_ACT_BIT  = 7;
  localparam int M4_DEA_BIT  = 6;
  localparam int MC_NT       = 0;
  localparam int MC_AUTO_ACT = 1;
  localparam int MC_AUTO_DEA = 2;
  localparam int FS_LSB      = 4;
  localparam int MM_EOC_LSB  = 0;
  localparam int MM_M4_LSB   = 2;
  localparam int MM_M56_LSB  = 4;
  localparam int MM_EOC_AUTO = 6;
  localparam int LB_LINE     = 0;
  localparam int LB_IDL      = 1;
  localparam int LB_FRM      = 2;
  localparam int LB_ANA      = 3;
  localparam int LB_TRANSP   = 4;
  localparam int CNT_NEBE    = 8;
  localparam int ST_FEBE_BIT = 16;
  localparam int ST_NEBE_BIT = 17;

  localparam logic [1:0] LVL_DEACT      = 2'h0;
  localparam logic [1:0] LVL_ACTIVATING = 2'h1;
  localparam logic [1:0] LVL_ACTIVE     = 2'h2;

  localparam logic [3:0] FS_IDLE  = 4'h0;
  localparam logic [3:0] FS_TONE  = 4'h1;
  localparam logic [3:0] FS_SYNC  = 4'h2;
  localparam logic [3:0] FS_SUPER = 4'h3;

  localparam logic [1:0] UPD_FRAME = 2'h0;
  localparam logic [1:0] UPD_BIT   = 2'h1;
  localparam logic [1:0] UPD_TWO   = 2'h2;
  localparam logic [1:0] UPD_THREE = 2'h3;

  typedef enum logic [1:0] {ST_DEACT, ST_TONE, ST_ACTIVATING, ST_ACTIVE} act_state_t;

  typedef logic [BD_W-1:0] bd_t;

  typedef struct packed {
    logic [23:0] eoc;
    logic [7:0]  m4;
    logic [15:0] m56;
  } maint_t;
endpackage : link_act_pkg

//--- design/rx_update_filter.sv
`timescale 1ns/1ps
`default_nettype none
module rx_update_filter
  import link_act_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         en,
  input  wire logic [1:0]   mode,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      val,
  output logic              upd
);
  typedef struct packed {
    logic [W-1:0] val;
    logic [W-1:0] cand;
    logic [1:0]   cnt;
    logic         upd;
  } flt_t;

  flt_t q, d;
  logic same;
  logic hit;

  assign same = (din == q.cand);

  always_comb begin
    d = q;
    d.upd = 1'b0;
    hit = 1'b0;
    if (en) begin
      d.cand = din;
      // Saturates so a long run of one value still counts as repeated
      d.cnt  = !same ? 2'h0 : (q.cnt == 2'h3) ? q.cnt : q.cnt + 2'h1;
      case (mode)
        UPD_FRAME: hit = !same;
        UPD_BIT:   hit = (din != q.val);
        UPD_TWO:   hit = (din != q.val) && same;
        UPD_THREE: hit = (din != q.val) && same && (q.cnt != 2'h0);
        default:   hit = 1'b0;
      endcase
      if (hit) begin
        d.val = din;
        d.upd = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign val = q.val;
  assign upd = q.upd;
endmodule : rx_update_filter
`default_nettype wire

//--- design/u_link_activation_maintenance.sv
// Notes on behaviour
// RULE_01: Start activation on request or wake tone
// RULE_02: LT watches network tone, NT line tone
// RULE_03: Activation runs alone; status shows level, errors
// RULE_04: Only LT deactivates, on deactivation request; LT and NT both also drop to ST_DEACT when sync is lost while active
// RULE_05: NT deactivation request arms warm start
// RULE_06: Framer state readable in maintenance control bits
// RULE_07: Superframe carries six eight-bit maintenance channels
// RULE_08: Four selectable receive update modes
// RULE_09: Act bit gates customer data when enabled
// RULE_10: NT dea bit raises deactivation request
// RULE_11: Receive registers update only with superframe sync
// RULE_12: NT eoc automatic or controller serviced
// RULE_13: Eoc update interrupts when enable bit two
// RULE_14: M4 receive and transmit registers, interrupt bit one
// RULE_15: M5/M6 paired registers, interrupt bit zero
// RULE_16: Febe, nebe states and counters readable
// RULE_17: Four loopbacks, any combination allowed
// RULE_18: Non-transparent loopback sends all ones downstream
// RULE_19: Line loopback returns received data to line
// RULE_20: Digital loopback returns digital input unchanged
// RULE_21: Framer loopback returns data and maintenance
// RULE_22: Analog loopback sends whole superframe out
// RULE_23: Network tone lasts six frames
// RULE_24: Line tone lasts two frames
`timescale 1ns/1ps
`default_nettype none
module u_link_activation_maintenance
  import link_act_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_CYC,
  parameter int          ADR_W        = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic             wb_we_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  irq,
  input  wire logic             tone_net_i,
  input  wire logic             tone_line_i,
  input  wire logic             sf_sync,
  input  wire logic             rx_sf_strobe,
  input  wire maint_t           rx_maint,
  input  wire logic             rx_febe,
  input  wire logic             rx_nebe,
  input  wire logic             tx_sf_strobe,
  output maint_t                tx_maint,
  output logic                  tone_tx,
  output logic                  line_deact,
  output logic                  line_disc,
  input  wire bd_t              idl_rx_bd,
  input  wire bd_t              line_rx_bd,
  output bd_t                   idl_tx_bd,
  output bd_t                   line_tx_bd
);
  typedef struct packed {
    act_state_t  st;
    logic [2:0]  tone_cnt;
    logic [15:0] div;
    logic        warm;
    logic        ack;
    logic [31:0] rdata;
    logic [2:0]  irq_en;
    logic [2:0]  irq_flag;
    logic        irq;
    logic [7:0]  m4_tx;
    logic [15:0] m56_tx;
    logic [23:0] eoc_tx;
    logic [2:0]  mctl;
    logic [6:0]  mmode;
    logic [4:0]  loopc;
    logic [7:0]  febe_cnt;
    logic [7:0]  nebe_cnt;
    logic        febe_s;
    logic        nebe_s;
    logic        dea_prev;
    logic        line_deact;
    logic        tone_tx;
    logic        disc;
    maint_t      txm;
    bd_t         idl_tx;
    bd_t         line_tx;
  } st_t;

  st_t q, d;

  logic        acc, wr, adr_ok;
  logic [3:0]  idx;
  logic        nt, lt, sync, rx_en, frame_tick;
  logic        lp_line, lp_idl, lp_frm, lp_ana, transp;
  logic        act_wr, dea_wr, dea_auto, dea_req, tone_seen;
  logic        data_ok;
  bd_t         idle_bd;
  maint_t      rx_src;
  logic [3:0]  fstate;
  logic [1:0]  lvl;
  logic [31:0] rd;
  logic [23:0] eoc_val;
  logic [7:0]  m4_val;
  logic [15:0] m56_val;
  logic        eoc_upd, m4_upd, m56_upd;

  function automatic logic [31:0] bmask(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
    return r;
  endfunction : bmask

  function automatic logic hit(input logic [3:0] r, input logic w, input logic [3:0] i,
                               input logic ok);
    return w && ok && (i == r);
  endfunction : hit

  // Write lands on the edge where the master sees ack
  assign acc    = wb_cyc_i && wb_stb_i;
  assign wr     = acc && q.ack && wb_we_i;
  assign idx    = wb_adr_i[5:2];
  assign adr_ok = (wb_adr_i[ADR_W-1:6] == '0);

  assign nt      = q.mctl[MC_NT];
  assign lt      = !nt;
  assign lp_line = q.loopc[LB_LINE];
  assign lp_idl  = q.loopc[LB_IDL];
  assign lp_frm  = q.loopc[LB_FRM];
  assign lp_ana  = q.loopc[LB_ANA];
  assign transp  = q.loopc[LB_TRANSP];

  assign sync      = sf_sync || lp_frm;
  assign rx_en     = sync && (lp_frm ? tx_sf_strobe : rx_sf_strobe); // RULE_11
  assign rx_src    = lp_frm ? q.txm : rx_maint; // RULE_21
  assign tone_seen = nt ? tone_line_i : tone_net_i; // RULE_02
  assign frame_tick = (q.div == 16'(FRAME_CYCLES - 1));

  assign act_wr   = hit(R_ACT_CTRL, wr, idx, adr_ok) && wb_sel_i[0] && wb_dat_i[ACT_REQ_BIT];
  assign dea_wr   = hit(R_ACT_CTRL, wr, idx, adr_ok) && wb_sel_i[0] && wb_dat_i[DEA_REQ_BIT];
  // Falling dea bit stands in for the controller's request
  assign dea_auto = nt && q.mctl[MC_AUTO_DEA] && q.dea_prev && !q.m4_tx[M4_DEA_BIT]; // RULE_10
  assign dea_req  = dea_wr || dea_auto;

  // NT idles at ones and LT at zeros until active, and while act is low with MC_AUTO_ACT set
  assign idle_bd = nt ? '1 : '0;
  assign data_ok = (q.st == ST_ACTIVE) && (!q.mctl[MC_AUTO_ACT] || q.m4_tx[M4_ACT_BIT]);

  rx_update_filter #(.W(24)) u_eoc_flt ( // RULE_08
    .clk     (clk),
    .sys_rst (sys_rst),
    .en      (rx_en),
    .mode    (q.mmode[MM_EOC_LSB +: 2]),
    .din     (rx_src.eoc),
    .val     (eoc_val),
    .upd     (eoc_upd)
  );

  rx_update_filter #(.W(8)) u_m4_flt ( // RULE_14
    .clk     (clk),
    .sys_rst (sys_rst),
    .en      (rx_en),
    .mode    (q.mmode[MM_M4_LSB +: 2]),
    .din     (rx_src.m4),
    .val     (m4_val),
    .upd     (m4_upd)
  );

  rx_update_filter #(.W(16)) u_m56_flt ( // RULE_15
    .clk     (clk),
    .sys_rst (sys_rst),
    .en      (rx_en),
    .mode    (q.mmode[MM_M56_LSB +: 2]),
    .din     (rx_src.m56),
    .val     (m56_val),
    .upd     (m56_upd)
  );

  always_comb begin
    case (q.st)
      ST_TONE:       fstate = FS_TONE;
      ST_ACTIVATING: fstate = FS_SYNC;
      ST_ACTIVE:     fstate = FS_SUPER;
      default:       fstate = FS_IDLE;
    endcase
    case (q.st)
      ST_ACTIVE:     lvl = LVL_ACTIVE;
      ST_DEACT:      lvl = LVL_DEACT;
      default:       lvl = LVL_ACTIVATING;
    endcase
  end

  // Unmapped offsets read as zero and ignore writes
  always_comb begin
    rd = '0;
    if (adr_ok) begin
      case (idx)
        R_ACT_STAT: begin // RULE_03
          rd[ST_ERR_BIT]           = q.nebe_s;
          rd[ST_SYNC_BIT]          = sf_sync;
          rd[ST_LVL_LSB +: 2]      = lvl;
          rd[ST_WARM_BIT]          = q.warm;
        end
        R_IRQ_EN:   rd[2:0]  = q.irq_en;
        R_IRQ_STAT: rd[2:0]  = q.irq_flag;
        R_M4_RX:    rd[7:0]  = m4_val;
        R_M4_TX:    rd[7:0]  = q.m4_tx;
        R_M56_RX:   rd[15:0] = m56_val;
        R_M56_TX:   rd[15:0] = q.m56_tx;
        R_MNT_CTRL: begin
          rd[2:0]           = q.mctl;
          rd[FS_LSB +: 4]   = fstate; // RULE_06
        end
        R_MNT_MODE: rd[6:0]  = q.mmode;
        R_EOC_RX:   rd[23:0] = eoc_val;
        R_EOC_TX:   rd[23:0] = q.eoc_tx;
        R_LOOP:     rd[4:0]  = q.loopc;
        R_ERR_CNT:  begin // RULE_16
          rd[7:0]                = q.febe_cnt;
          rd[CNT_NEBE +: 8]      = q.nebe_cnt;
          rd[ST_FEBE_BIT]        = q.febe_s;
          rd[ST_NEBE_BIT]        = q.nebe_s;
        end
        default:    rd = '0;
      endcase
    end
  end

  always_comb begin
    d = q;
    d.ack        = acc && !q.ack;
    d.rdata      = (acc && !q.ack) ? rd : q.rdata;
    d.line_deact = 1'b0;
    d.dea_prev   = q.m4_tx[M4_DEA_BIT];
    d.div        = frame_tick ? '0 : q.div + 16'h0001;

    if (hit(R_IRQ_EN, wr, idx, adr_ok) && wb_sel_i[0]) d.irq_en = wb_dat_i[2:0];
    if (hit(R_M4_TX, wr, idx, adr_ok) && wb_sel_i[0]) d.m4_tx = wb_dat_i[7:0];
    if (hit(R_M56_TX, wr, idx, adr_ok)) begin
      d.m56_tx = 16'(bmask({16'h0000, q.m56_tx}, wb_dat_i, wb_sel_i));
    end
    if (hit(R_EOC_TX, wr, idx, adr_ok)) begin
      d.eoc_tx = 24'(bmask({8'h00, q.eoc_tx}, wb_dat_i, wb_sel_i));
    end
    if (hit(R_MNT_CTRL, wr, idx, adr_ok) && wb_sel_i[0]) d.mctl = wb_dat_i[2:0];
    if (hit(R_MNT_MODE, wr, idx, adr_ok) && wb_sel_i[0]) d.mmode = wb_dat_i[6:0];
    if (hit(R_LOOP, wr, idx, adr_ok) && wb_sel_i[0]) d.loopc = wb_dat_i[4:0]; // RULE_17

    // New update beats a simultaneous write-one clear
    d.irq_flag = q.irq_flag;
    if (hit(R_IRQ_STAT, wr, idx, adr_ok) && wb_sel_i[0]) d.irq_flag = q.irq_flag & ~wb_dat_i[2:0];
    d.irq_flag[IRQ_EOC] = d.irq_flag[IRQ_EOC] || eoc_upd; // RULE_13
    d.irq_flag[IRQ_M4]  = d.irq_flag[IRQ_M4] || m4_upd; // RULE_14
    d.irq_flag[IRQ_M56] = d.irq_flag[IRQ_M56] || m56_upd; // RULE_15
    d.irq = |(d.irq_flag & d.irq_en);

    if (hit(R_ERR_CNT, wr, idx, adr_ok)) begin
      d.febe_cnt = '0;
      d.nebe_cnt = '0;
    end else if (rx_en) begin // RULE_16
      d.febe_cnt = q.febe_cnt + {7'h00, rx_febe};
      d.nebe_cnt = q.nebe_cnt + {7'h00, rx_nebe};
    end
    if (rx_en) begin
      d.febe_s = rx_febe;
      d.nebe_s = rx_nebe;
    end

    case (q.st)
      ST_DEACT: begin
        if (act_wr || tone_seen) begin // RULE_01
          d.st       = ST_TONE;
          d.tone_tx  = 1'b1;
          d.tone_cnt = nt ? NET_TONE_FRAMES : LINE_TONE_FRAMES; // RULE_23 RULE_24
          d.div      = '0;
        end
      end
      ST_TONE: begin
        if (frame_tick) begin
          if (q.tone_cnt == TONE_LAST) begin
            d.tone_tx = 1'b0;
            d.st      = ST_ACTIVATING;
          end else begin
            d.tone_cnt = q.tone_cnt - 3'h1;
          end
        end
      end
      ST_ACTIVATING: begin
        if (sync) begin // RULE_03
          d.st   = ST_ACTIVE;
          d.warm = 1'b0;
        end
      end
      ST_ACTIVE: begin
        if (nt && dea_req) d.warm = 1'b1; // RULE_05
        if (!sync) d.st = ST_DEACT;
      end
      default: d.st = ST_DEACT;
    endcase

    // Only the LT may take the loop down
    if (lt && dea_wr && q.st != ST_DEACT) begin // RULE_04
      d.st         = ST_DEACT;
      d.tone_tx    = 1'b0;
      d.line_deact = 1'b1;
    end

    if (tx_sf_strobe) begin // RULE_07 RULE_22
      d.txm.eoc = (nt && q.mmode[MM_EOC_AUTO]) ? eoc_val : q.eoc_tx; // RULE_12
      d.txm.m4  = q.m4_tx;
      d.txm.m56 = q.m56_tx;
    end

    if (lp_line) d.line_tx = line_rx_bd; // RULE_19
    else if ((lp_idl || lp_frm) && !transp) d.line_tx = '1; // RULE_18
    else if (lp_ana || data_ok) d.line_tx = idl_rx_bd; // RULE_22
    else d.line_tx = idle_bd; // RULE_09

    if (lp_idl || lp_frm) d.idl_tx = idl_rx_bd; // RULE_20 RULE_21
    else if (lp_line && !transp) d.idl_tx = '1; // RULE_18
    else if (lp_ana || data_ok) d.idl_tx = line_rx_bd;
    else d.idl_tx = idle_bd; // RULE_09

    d.disc = lp_ana;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o   = q.rdata;
  assign wb_ack_o   = q.ack;
  assign irq        = q.irq;
  assign tx_maint   = q.txm;
  assign tone_tx    = q.tone_tx;
  assign line_deact = q.line_deact;
  assign line_disc  = q.disc;
  assign idl_tx_bd  = q.idl_tx;
  assign line_tx_bd = q.line_tx;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_act_start;
    (q.st == ST_DEACT && act_wr) |=> (q.st == ST_TONE && q.tone_tx);
  endproperty
  a_act_start: assert property (p_act_start) else $error("activation did not start"); // RULE_01

  property p_lt_ignores_line_tone;
    (q.st == ST_DEACT && lt && !act_wr && tone_line_i && !tone_net_i) |=> q.st == ST_DEACT;
  endproperty
  a_lt_ignores_line_tone: assert property (p_lt_ignores_line_tone) // RULE_02
    else $error("LT woke on line tone");

  property p_sync_up;
    (q.st == ST_ACTIVATING && sync && !(lt && dea_wr)) |=> (q.st == ST_ACTIVE && !q.warm);
  endproperty
  a_sync_up: assert property (p_sync_up) else $error("sync did not activate"); // RULE_03

  property p_lt_deact;
    (lt && dea_wr && q.st == ST_ACTIVE) |=> (q.st == ST_DEACT && q.line_deact) ##1 !q.line_deact;
  endproperty
  a_lt_deact: assert property (p_lt_deact) else $error("LT deactivation wrong"); // RULE_04

  property p_nt_warm;
    (nt && dea_wr && q.st == ST_ACTIVE) |=> (q.warm && !q.line_deact);
  endproperty
  a_nt_warm: assert property (p_nt_warm) else $error("NT warm start not armed"); // RULE_05

  property p_tone_len_net;
    (q.st == ST_DEACT && nt && act_wr) |=> q.tone_cnt == NET_TONE_FRAMES;
  endproperty
  a_tone_len_net: assert property (p_tone_len_net) else $error("network tone length"); // RULE_23

  property p_tone_len_line;
    (q.st == ST_DEACT && lt && act_wr) |=> q.tone_cnt == LINE_TONE_FRAMES;
  endproperty
  a_tone_len_line: assert property (p_tone_len_line) else $error("line tone length"); // RULE_24

  property p_rx_hold;
    !rx_en |=> $stable(m4_val);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("M4 receive moved without sync"); // RULE_11

  property p_eoc_irq;
    (eoc_upd && q.irq_en[IRQ_EOC] && !wr) |=> q.irq;
  endproperty
  a_eoc_irq: assert property (p_eoc_irq) else $error("eoc update gave no interrupt"); // RULE_13

  property p_act_gate;
    (nt && q.mctl[MC_AUTO_ACT] && !q.m4_tx[M4_ACT_BIT] && q.loopc == '0) |=> q.line_tx == '1;
  endproperty
  a_act_gate: assert property (p_act_gate) else $error("act bit did not gate data"); // RULE_09

  property p_nontransp;
    (lp_line && !transp && !lp_idl && !lp_frm) |=> q.idl_tx == '1;
  endproperty
  a_nontransp: assert property (p_nontransp) else $error("idle code missing"); // RULE_18

  property p_idl_loop;
    lp_idl |=> q.idl_tx == $past(idl_rx_bd);
  endproperty
  a_idl_loop: assert property (p_idl_loop) else $error("digital loopback wrong"); // RULE_20

  property p_line_loop;
    lp_line |=> q.line_tx == $past(line_rx_bd);
  endproperty
  a_line_loop: assert property (p_line_loop) else $error("line loopback wrong"); // RULE_19

  c_active: cover property (q.st == ST_ACTIVATING ##1 q.st == ST_ACTIVE);
  c_lt_down: cover property (q.line_deact);
  c_irq: cover property (!q.irq ##1 q.irq);
  c_frm_loop: cover property (lp_frm && m4_upd);
endmodule : u_link_activation_maintenance
`default_nettype wire

//--- sim/far_end_model.sv
`timescale 1ns/1ps
`default_nettype none
module far_end_model
  import link_act_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire logic   sync_cmd,
  input  wire maint_t word,
  input  wire logic   febe,
  input  wire logic   nebe,
  output logic        sf_sync,
  output logic        rx_sf_strobe,
  output maint_t      rx_maint,
  output logic        rx_febe,
  output logic        rx_nebe,
  output logic        tx_sf_strobe,
  output bd_t         line_rx_bd
);
  logic [4:0] cnt_q;

  // Short superframe so register traffic fits between strobes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q        <= 5'h00;
      sf_sync      <= 1'b0;
      rx_sf_strobe <= 1'b0;
      tx_sf_strobe <= 1'b0;
      rx_maint     <= '0;
      rx_febe      <= 1'b0;
      rx_nebe      <= 1'b0;
      line_rx_bd   <= '0;
    end else begin
      cnt_q        <= cnt_q + 5'h01;
      sf_sync      <= sync_cmd;
      rx_sf_strobe <= (cnt_q == 5'h1F);
      tx_sf_strobe <= (cnt_q == 5'h0F);
      // Line data changes every clock so a stale copy shows up
      line_rx_bd   <= bd_t'(line_rx_bd * 3 + 7);
      if (cnt_q == 5'h1F) begin
        rx_maint <= word;
        rx_febe  <= febe;
        rx_nebe  <= nebe;
      end
    end
  end
endmodule : far_end_model
`default_nettype wire

//--- sim/u_link_activation_maintenance_test.sv
`timescale 1ns/1ps
`default_nettype none
module u_link_activation_maintenance_test
  import link_act_pkg::*;
;
  localparam int F = 8;
  logic        clk, sys_rst, we, cyc, stb, wb_ack_o, irq, u;
  logic        tone_tx, line_deact, line_disc, tone_net_i, tone_line_i;
  logic        sf_sync, rx_sf_strobe, rx_febe, rx_nebe, tx_sf_strobe;
  logic        sync_cmd, febe, nebe;
  logic [7:0]  adr, st, p1, p2, v;
  logic [31:0] wdat, wb_dat_o, q;
  logic [3:0]  sel;
  maint_t      word, rx_maint, tx_maint;
  bd_t         idl_rx_bd, line_rx_bd, idl_tx_bd, line_tx_bd, pi, pl;
  int          failures, checked, tone_cyc, dea_cnt, fe, ne, mode;

  u_link_activation_maintenance #(.FRAME_CYCLES(F)) dut (
    .clk, .sys_rst, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o, .wb_ack_o, .irq, .tone_net_i,
    .tone_line_i, .sf_sync, .rx_sf_strobe, .rx_maint, .rx_febe, .rx_nebe,
    .tx_sf_strobe, .tx_maint, .tone_tx, .line_deact, .line_disc, .idl_rx_bd,
    .line_rx_bd, .idl_tx_bd, .line_tx_bd);

  far_end_model far (
    .clk, .sys_rst, .sync_cmd, .word, .febe, .nebe, .sf_sync, .rx_sf_strobe,
    .rx_maint, .rx_febe, .rx_nebe, .tx_sf_strobe, .line_rx_bd);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(negedge clk) begin
    if (tone_tx === 1'b1) tone_cyc++;
    if (line_deact === 1'b1) dea_cnt++;
    if (rx_sf_strobe === 1'b1 && sf_sync === 1'b1) begin
      fe += rx_febe;
      ne += rx_nebe;
    end
  end

  function automatic logic [7:0] ad(input logic [3:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ad

  task automatic complete_run();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk

  // Holds the request until ack is sampled high, releases at that edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    chk("wb_ack_drop", 32'h0, {31'h0, wb_ack_o});
    adr  <= a;
    we   <= w;
    wdat <= d;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rchk(input logic [3:0] i, input logic [31:0] m, input logic [31:0] e,
                      input string s);
    wb(ad(i), 1'b0, 32'h0);
    chk(s, e, q & m);
  endtask : rchk

  task automatic sf();
    int n;
    logic [7:0] w;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rx_sf_strobe !== 1'b1 && n < 100);
    w = rx_maint.m4;
    u = 1'b0;
    if (sf_sync === 1'b1) begin
      case (mode)
        0: u = (w != p1);
        1: u = (w != st);
        2: u = (w == p1) && (w != st);
        default: u = (w == p1) && (w == p2) && (w != st);
      endcase
      if (u) st = w;
      p2 = p1;
      p1 = w;
    end
    @(posedge clk);
  endtask : sf

  task automatic tone_end();
    int n;
    n = 0;
    while (tone_tx !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    while (tone_tx !== 1'b0 && n < 600) begin
      @(negedge clk);
      n++;
    end
  endtask : tone_end

  initial begin
    #400000;
    failures++;
    complete_run();
  end

  initial begin
    {cyc, stb, we, tone_net_i, tone_line_i, sync_cmd, febe, nebe} = '0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hF;
    word = '0;
    idl_rx_bd = '0;
    {st, p1, p2} = '0;
    sys_rst = 1'b1;
    void'($urandom(25));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(R_IRQ_EN, 32'hFFFFFFFF, 32'h0, "irq_en_reset");
    wb(8'h40, 1'b1, 32'hFFFFFFFF);
    wb(8'h40, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(ad(R_ACT_CTRL), 1'b1, 32'h1 << ACT_REQ_BIT);
    tone_end();
    chk("lt_tone", LINE_TONE_FRAMES * F, tone_cyc);
    rchk(R_ACT_STAT, 32'hC, {28'h0, LVL_ACTIVATING, 2'h0}, "level");
    sync_cmd <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(R_ACT_STAT, 32'hE, {28'h0, LVL_ACTIVE, 2'h2}, "level");
    wb(ad(R_IRQ_EN), 1'b1, 32'h7);
    for (int m = 0; m < 4; m++) begin
      mode = m;
      wb(ad(R_MNT_MODE), 1'b1, {26'h0, m[1:0], m[1:0], m[1:0]});
      repeat (6) begin
        sf();
        v = ($urandom % 2) ? 8'h5A : 8'hC3;
        word <= {{3{v}}, v, {2{v}}};
        febe <= 1'($urandom);
        nebe <= 1'($urandom);
        rchk(R_M4_RX, 32'hFF, {24'h0, st}, "m4_rx");
        rchk(R_EOC_RX, 32'hFFFFFF, {8'h0, {3{st}}}, "eoc_rx");
        rchk(R_M56_RX, 32'hFFFF, {16'h0, {2{st}}}, "m56_rx");
        chk("irq", {31'h0, u}, {31'h0, irq});
        rchk(R_IRQ_STAT, 32'h7, {29'h0, {3{u}}}, "irq_flags");
        wb(ad(R_IRQ_STAT), 1'b1, 32'h7);
      end
    end
    febe <= 1'b0;
    nebe <= 1'b0;
    sf();
    sf();
    rchk(R_ERR_CNT, 32'hFFFF, {16'h0, ne[7:0], fe[7:0]}, "err_cnt");
    wb(ad(R_ACT_CTRL), 1'b1, 32'h1 << DEA_REQ_BIT);
    repeat (3) @(posedge clk);
    chk("deact_pulse", 1, dea_cnt);
    rchk(R_ACT_STAT, 32'hC, {28'h0, LVL_DEACT, 2'h0}, "level");
    sync_cmd <= 1'b0;
    word <= ~word;
    repeat (3) sf();
    rchk(R_M4_RX, 32'hFF, {24'h0, st}, "m4_hold");
    wb(ad(R_MNT_CTRL), 1'b1, 32'h1 << MC_NT);
    tone_cyc = 0;
    tone_net_i <= 1'b1;
    repeat (20) @(posedge clk);
    tone_net_i <= 1'b0;
    chk("nt_net_tone", 0, tone_cyc);
    tone_line_i <= 1'b1;
    rchk(R_MNT_CTRL, 32'hF0, {24'h0, FS_TONE, 4'h0}, "framer_state");
    tone_line_i <= 1'b0;
    tone_end();
    chk("nt_tone", NET_TONE_FRAMES * F, tone_cyc);
    @(posedge clk);
    sync_cmd <= 1'b1;
    repeat (4) @(posedge clk);
    wb(ad(R_ACT_CTRL), 1'b1, 32'h1 << DEA_REQ_BIT);
    rchk(R_ACT_STAT, 32'h1C, {27'h0, 1'b1, LVL_ACTIVE, 2'h0}, "nt_warm");
    wb(ad(R_MNT_CTRL), 1'b1, 32'h1 << MC_NT | 32'h1 << MC_AUTO_ACT);
    repeat (2) @(posedge clk);
    chk("act_gate_line", 32'h3FFFF, {14'h0, line_tx_bd});
    chk("act_gate_idl", 32'h3FFFF, {14'h0, idl_tx_bd});
    wb(ad(R_LOOP), 1'b1, 32'h3);
    repeat (20) begin
      @(posedge clk);
      pi = idl_rx_bd;
      pl = line_rx_bd;
      idl_rx_bd <= bd_t'($urandom);
      @(negedge clk);
      chk("idl_loop", {14'h0, pi}, {14'h0, idl_tx_bd});
      chk("line_loop", {14'h0, pl}, {14'h0, line_tx_bd});
    end
    wb(ad(R_M4_TX), 1'b1, 32'hA5);
    wb(ad(R_LOOP), 1'b1, 32'h1 << LB_ANA);
    repeat (40) @(posedge clk);
    chk("tx_m4", 32'hA5, {24'h0, tx_maint.m4});
    chk("line_disc", 32'h1, {31'h0, line_disc});
    chk("ana_loop", {14'h0, idl_rx_bd}, {14'h0, line_tx_bd});
    complete_run();
  end
endmodule : u_link_activation_maintenance_test
`default_nettype wire
